// ---- logic/scd_top.sv ----
// System clock derivation: input selection, reset word capture, dividers, registers
`timescale 1ns/1ps

module scd_top
  import scd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        clkin_i,
  input  wire logic        agent_clk_i,
  input  wire logic        sync_in_i,
  input  wire logic        halve_strap_i,
  input  wire logic        host_mode_select_i,
  input  wire logic        bus_clock_drive_i,
  input  wire logic [1:0]  reset_source_i,
  input  wire logic [31:0] reset_word_low_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic             sync_out_o,
  output logic [4:0]       bus_clk_out_o,
  output logic             mem1_clock_p_o,
  output logic             mem1_clock_n_o,
  output logic             local_sync_output_o,
  output logic [2:0]       local_bus_clock_outputs_o,
  output logic             sec_clk_o,
  output logic             dma_clk_o,
  output logic [7:0]       csb_mult_o,
  output logic [6:0]       cpu_pll_select_o
);

  // ----------------------------------------------------------------
  // Reset word capture
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RESET   = 3'b001,
    ST_CAPTURE = 3'b010,
    ST_RUN     = 3'b100
  } scd_state_t;

  scd_state_t state_reg;
  scd_state_t state_next;
  scd_reset_word_low_t  reset_word_low_reg;
  scd_reset_word_low_t  reset_word_low_next;
  scd_mode_t  mode_reg;
  scd_mode_t  mode_next;

  function automatic logic [31:0] pick_rcw(input logic [1:0] src, input logic [31:0] pins);
    case (src)
      2'h1:    pick_rcw = RCW_OPT1;
      2'h2:    pick_rcw = RCW_OPT2;
      2'h3:    pick_rcw = RCW_OPT3;
      default: pick_rcw = pins;
    endcase
  endfunction

  // Straps are static around reset, so they are sampled once, in ST_CAPTURE, on the second clock edge after release
  always_comb
  begin
    state_next = state_reg;
    reset_word_low_next  = reset_word_low_reg;
    mode_next  = mode_reg;
    case (state_reg)
      ST_RESET:   state_next = ST_CAPTURE;
      ST_CAPTURE:
      begin
        reset_word_low_next                  = pick_rcw(reset_source_i, reset_word_low_i);
        mode_next.host_mode_select = host_mode_select_i;
        mode_next.bus_clock_drive  = bus_clock_drive_i;
        mode_next.halve            = halve_strap_i;
        mode_next.run              = 1'b1;
        if (!host_mode_select_i)
        begin
          mode_next.prim_sel = PRIM_AGENT;
        end
        else if (!bus_clock_drive_i)
        begin
          mode_next.prim_sel = PRIM_SYNC_IN;
        end
        else
        begin
          mode_next.prim_sel = PRIM_CLKIN;
        end
        state_next = ST_RUN;
      end
      ST_RUN:     state_next = ST_RUN;
      default:    state_next = ST_RESET;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= ST_RESET;
      reset_word_low_reg  <= '0;
      mode_reg  <= '0;
    end
    else
    begin
      state_reg <= state_next;
      reset_word_low_reg  <= reset_word_low_next;
      mode_reg  <= mode_next;
    end
  end

  // ----------------------------------------------------------------
  // Primary clock selection and bus clock outputs
  // ----------------------------------------------------------------
  // Pin clocks are oversampled, so only inputs well below a quarter of
  // the reference rate are followed faithfully
  logic [2:0] pin_lvl;
  logic       prim_lvl;
  logic       prim_prev_reg;
  logic       sync_reg;
  logic       sync_next;
  logic [4:0] gate_reg;
  logic [4:0] gate_next;
  logic [4:0] bclk_reg;
  logic [4:0] bclk_next;
  logic [4:0] out_en_reg;

  scd_sync #(.W(3)) u_sync (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .pin_i   ({sync_in_i, agent_clk_i, clkin_i}),
    .level_o (pin_lvl)
  );

  always_comb
  begin
    case (mode_reg.prim_sel)
      PRIM_AGENT:   prim_lvl = pin_lvl[1];
      PRIM_SYNC_IN: prim_lvl = pin_lvl[2];
      default:      prim_lvl = pin_lvl[0];
    endcase
    sync_next = 1'b0;
    if (mode_reg.run)
    begin
      if (mode_reg.halve)
      begin
        sync_next = sync_reg ^ (prim_lvl & ~prim_prev_reg);
      end
      else
      begin
        sync_next = prim_lvl;
      end
    end
    // An enable is taken over only while the sync clock is low
    gate_next = sync_reg ? gate_reg : out_en_reg;
    bclk_next = gate_next & {NUM_BUS_CLK{sync_next}};
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      prim_prev_reg <= 1'b0;
      sync_reg      <= 1'b0;
      gate_reg      <= '0;
      bclk_reg      <= '0;
    end
    else
    begin
      prim_prev_reg <= prim_lvl;
      sync_reg      <= sync_next;
      gate_reg      <= gate_next;
      bclk_reg      <= bclk_next;
    end
  end

  // ----------------------------------------------------------------
  // Derived clocks (reference runs at twice the bus clock rate)
  // ----------------------------------------------------------------
  logic [1:0] lb_div_reg;
  logic [1:0] sec_rate_reg;
  logic       dma_rate_reg;
  logic       csb_tick_reg;
  logic       lb_tick;
  logic       mem_tick;
  logic [2:0] lb_half;
  logic [2:0] sec_half;
  logic       mem_div;
  logic       lb_div_clk;
  logic       run;

  assign run      = mode_reg.run;
  assign lb_tick  = reset_word_low_reg.local_bus_clock_mode | csb_tick_reg;
  assign mem_tick = reset_word_low_reg.mem1_clock_mode | csb_tick_reg;

  always_comb
  begin
    case (lb_div_reg)
      2'h0:    lb_half = HALF_LB_D2;
      2'h1:    lb_half = HALF_LB_D4;
      default: lb_half = HALF_LB_D8;
    endcase
    // Full rate is allowed only for slow bus clocks; software must check
    case (sec_rate_reg)
      SEC_FULL: sec_half = HALF_CSB;
      SEC_HALF: sec_half = HALF_CSB2;
      default:  sec_half = HALF_CSB3;
    endcase
  end

  scd_clk_div u_mem_div (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .tick_i (mem_tick),
    .on_i   (run),
    .half_i (HALF_MEM),
    .clk_o  (mem_div)
  );

  scd_clk_div u_lb_div (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .tick_i (lb_tick),
    .on_i   (run),
    .half_i (lb_half),
    .clk_o  (lb_div_clk)
  );

  scd_clk_div u_sec_div (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .tick_i (1'b1),
    .on_i   (run && sec_rate_reg != SEC_OFF),
    .half_i (sec_half),
    .clk_o  (sec_clk_o)
  );

  scd_clk_div u_dma_div (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .tick_i (1'b1),
    .on_i   (run & dma_rate_reg),
    .half_i (HALF_CSB),
    .clk_o  (dma_clk_o)
  );

  logic       memp_reg;
  logic       memn_reg;
  logic [3:0] lbo_reg;
  logic [7:0] csb_mult_reg;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      csb_tick_reg <= 1'b0;
      memp_reg     <= 1'b0;
      memn_reg     <= 1'b0;
      lbo_reg      <= '0;
      csb_mult_reg <= 8'h00;
    end
    else
    begin
      csb_tick_reg <= ~csb_tick_reg;
      memp_reg     <= mem_div;
      memn_reg     <= run & ~mem_div;
      lbo_reg      <= {4{lb_div_clk}};
      csb_mult_reg <= {4'h0, reset_word_low_reg.system_pll_multiplier}
                      << mode_reg.halve;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite register slave
  // ----------------------------------------------------------------
  logic        aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [4:0]  out_en_next;
  logic [1:0]  lb_div_next, sec_rate_next;
  logic        dma_rate_next;

  function automatic logic [31:0] read_word(input logic [7:0] a);
    read_word = 32'h0000_0000;
    case (a)
      OFS_OUT_CLK_CTRL: read_word[4:0] = out_en_reg;
      OFS_LB_RATIO:     read_word[1:0] = lb_div_reg;
      OFS_UNIT_CLK:
      begin
        read_word[POS_SEC_RATE +: 2] = sec_rate_reg;
        read_word[POS_DMA_RATE]      = dma_rate_reg;
      end
      OFS_RESET_LOW:    read_word = reset_word_low_reg;
      OFS_STATUS:
      begin
        read_word[POS_HOST]          = mode_reg.host_mode_select;
        read_word[POS_DRIVE]         = mode_reg.bus_clock_drive;
        read_word[POS_HALVE]         = mode_reg.halve;
        read_word[POS_RUN]           = mode_reg.run;
        read_word[POS_PRIM_SEL +: 2] = mode_reg.prim_sel;
      end
      OFS_RATIOS:
      begin
        read_word[POS_CSB_MULT +: 8] = csb_mult_reg;
        read_word[POS_CE_MULT +: 5]  = reset_word_low_reg.engine_pll_multiplier;
        read_word[POS_CE_DIV +: 2]   = {1'b0, reset_word_low_reg.engine_pll_divider} + 2'h1;
      end
      default:          read_word = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= OFS_RATIOS) && (a[1:0] == 2'h0);
  endfunction

  always_comb
  begin
    aw_have_next  = aw_have_reg;
    w_have_next   = w_have_reg;
    awaddr_next   = awaddr_reg;
    wdata_next    = wdata_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    rvalid_next   = rvalid_reg;
    rresp_next    = rresp_reg;
    rdata_next    = rdata_reg;
    out_en_next   = out_en_reg;
    lb_div_next   = lb_div_reg;
    sec_rate_next = sec_rate_reg;
    dma_rate_next = dma_rate_reg;
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      aw_have_next = 1'b1;
      awaddr_next  = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      w_have_next = 1'b1;
      wdata_next  = s_axi_wdata_i;
    end
    if (bvalid_reg && s_axi_bready_i)
    begin
      bvalid_next = 1'b0;
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg)
    begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = mapped(awaddr_reg) ? AXI_OKAY : AXI_SLVERR;
      if (s_axi_wstrb_i[0] || 1'b1)
      begin
        case (awaddr_reg)
          OFS_OUT_CLK_CTRL: out_en_next = wdata_reg[4:0];
          OFS_LB_RATIO:     lb_div_next = wdata_reg[1:0];
          OFS_UNIT_CLK:
          begin
            sec_rate_next = wdata_reg[POS_SEC_RATE +: 2];
            dma_rate_next = wdata_reg[POS_DMA_RATE];
          end
          default:          out_en_next = out_en_reg;
        endcase
      end
    end
    if (rvalid_reg && s_axi_rready_i)
    begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      rvalid_next = 1'b1;
      rdata_next  = read_word(s_axi_araddr_i);
      rresp_next  = mapped(s_axi_araddr_i) ? AXI_OKAY : AXI_SLVERR;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h0000_0000;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= AXI_OKAY;
      rvalid_reg   <= 1'b0;
      rresp_reg    <= AXI_OKAY;
      rdata_reg    <= 32'h0000_0000;
      out_en_reg   <= RST_OUT_EN;
      lb_div_reg   <= RST_LB_DIV;
      sec_rate_reg <= RST_SEC_RATE;
      dma_rate_reg <= RST_DMA_RATE;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_arready_o <= 1'b0;
    end
    else
    begin
      aw_have_reg  <= aw_have_next;
      w_have_reg   <= w_have_next;
      awaddr_reg   <= awaddr_next;
      wdata_reg    <= wdata_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      rvalid_reg   <= rvalid_next;
      rresp_reg    <= rresp_next;
      rdata_reg    <= rdata_next;
      out_en_reg   <= out_en_next;
      lb_div_reg   <= lb_div_next;
      sec_rate_reg <= sec_rate_next;
      dma_rate_reg <= dma_rate_next;
      s_axi_awready_o <= !aw_have_next && !bvalid_next && !s_axi_awready_o;
      s_axi_wready_o  <= !w_have_next && !bvalid_next && !s_axi_wready_o;
      s_axi_arready_o <= !rvalid_next && !s_axi_arready_o;
    end
  end

  assign s_axi_bvalid_o            = bvalid_reg;
  assign s_axi_bresp_o             = bresp_reg;
  assign s_axi_rvalid_o            = rvalid_reg;
  assign s_axi_rresp_o             = rresp_reg;
  assign s_axi_rdata_o             = rdata_reg;
  assign sync_out_o                = sync_reg;
  assign bus_clk_out_o             = bclk_reg;
  assign mem1_clock_p_o            = memp_reg;
  assign mem1_clock_n_o            = memn_reg;
  assign local_sync_output_o       = lbo_reg[3];
  assign local_bus_clock_outputs_o = lbo_reg[2:0];
  assign csb_mult_o                = csb_mult_reg;
  assign cpu_pll_select_o          = reset_word_low_reg.cpu_pll_select;

endmodule

// ---- logic/scd_pkg.sv ----
// Constants, field layouts and carrier types for the system clock derivation block
package scd_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_OUT_CLK_CTRL = 8'h00;
  localparam logic [7:0] OFS_LB_RATIO     = 8'h04;
  localparam logic [7:0] OFS_UNIT_CLK     = 8'h08;
  localparam logic [7:0] OFS_RESET_LOW    = 8'h0C;
  localparam logic [7:0] OFS_STATUS       = 8'h10;
  localparam logic [7:0] OFS_RATIOS       = 8'h14;

  localparam int NUM_BUS_CLK = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] RST_OUT_EN   = 5'h00;
  localparam logic [1:0] RST_LB_DIV   = 2'h0;
  localparam logic [1:0] RST_SEC_RATE = 2'h3;
  localparam logic       RST_DMA_RATE = 1'b1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_SEC_RATE = 0;
  localparam int POS_DMA_RATE = 4;
  localparam int POS_HOST     = 0;
  localparam int POS_DRIVE    = 1;
  localparam int POS_HALVE    = 2;
  localparam int POS_RUN      = 3;
  localparam int POS_PRIM_SEL = 4;
  localparam int POS_CSB_MULT = 0;
  localparam int POS_CE_MULT  = 8;
  localparam int POS_CE_DIV   = 16;

  // Security core rate codes
  localparam logic [1:0] SEC_OFF   = 2'h0;
  localparam logic [1:0] SEC_FULL  = 2'h1;
  localparam logic [1:0] SEC_HALF  = 2'h2;
  localparam logic [1:0] SEC_THIRD = 2'h3;

  // Half periods in reference ticks (reference is twice the bus rate)
  localparam logic [2:0] HALF_CSB   = 3'h1;
  localparam logic [2:0] HALF_CSB2  = 3'h2;
  localparam logic [2:0] HALF_CSB3  = 3'h3;
  localparam logic [2:0] HALF_MEM   = 3'h1;
  localparam logic [2:0] HALF_LB_D2 = 3'h1;
  localparam logic [2:0] HALF_LB_D4 = 3'h2;
  localparam logic [2:0] HALF_LB_D8 = 3'h4;

  // Built-in reset word options (values arbitrary but plausible)
  localparam logic [31:0] RCW_OPT1 = 32'h0002_0034;
  localparam logic [31:0] RCW_OPT2 = 32'h0003_0044;
  localparam logic [31:0] RCW_OPT3 = 32'h0103_0054;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] spare;
    logic       mem1_clock_mode;
    logic       local_bus_clock_mode;
    logic [6:0] spare2;
    logic       engine_pll_divider;
    logic [4:0] engine_pll_multiplier;
    logic [6:0] cpu_pll_select;
    logic [3:0] system_pll_multiplier;
  } scd_reset_word_low_t;

  typedef struct packed {
    logic       run;
    logic       halve;
    logic       bus_clock_drive;
    logic       host_mode_select;
    logic [1:0] prim_sel;
  } scd_mode_t;

  localparam logic [1:0] PRIM_CLKIN   = 2'h0;
  localparam logic [1:0] PRIM_AGENT   = 2'h1;
  localparam logic [1:0] PRIM_SYNC_IN = 2'h2;

endpackage

// ---- logic/scd_sync.sv ----
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module scd_sync
  import scd_pkg::*;
#(
  parameter int W = 3
)(
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] lvl_reg;
  logic [W-1:0] lvl_next;

  // A change counts only once stages two and three agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      lvl_reg <= '0;
    end
    else
    begin
      s1_reg  <= pin_i;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level_o = lvl_reg;

endmodule

// ---- logic/scd_clk_div.sv ----
// Glitch-free programmable clock divider with gated shut-off
`timescale 1ns/1ps
module scd_clk_div
  import scd_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       tick_i,
  input  wire logic       on_i,
  input  wire logic [2:0] half_i,
  output logic            clk_o
);

  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [2:0] half_reg;
  logic [2:0] half_next;
  logic       on_reg;
  logic       on_next;
  logic       out_reg;
  logic       out_next;

  // New settings are taken only at the start of a low phase, so a
  // pulse already under way always completes at its old width
  always_comb
  begin
    cnt_next  = cnt_reg;
    half_next = half_reg;
    on_next   = on_reg;
    out_next  = out_reg;
    if (tick_i)
    begin
      if (!out_reg && cnt_reg == 3'h0)
      begin
        on_next   = on_i;
        half_next = half_i;
      end
      if (on_next)
      begin
        if (cnt_reg + 3'h1 >= half_next)
        begin
          cnt_next = 3'h0;
          out_next = ~out_reg;
        end
        else
        begin
          cnt_next = cnt_reg + 3'h1;
        end
      end
      else
      begin
        cnt_next = 3'h0;
        out_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_reg  <= 3'h0;
      half_reg <= 3'h1;
      on_reg   <= 1'b0;
      out_reg  <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      half_reg <= half_next;
      on_reg   <= on_next;
      out_reg  <= out_next;
    end
  end

  assign clk_o = out_reg;

endmodule

// ---- bench/scd_board.sv ----
// Board model: free-running PCI clock source and sync feedback trace
`timescale 1ns/1ps
module scd_board
(
  input  wire logic sync_out_i,
  input  wire logic agent_i,
  input  wire logic ext_i,
  output logic      clkin_o,
  output logic      agent_clk_o,
  output logic      sync_in_o
);
  logic osc = 1'b0;
  // Slow enough for the three-flop pin synchroniser
  initial forever #160 osc = ~osc;
  assign clkin_o     = agent_i ? 1'b0 : osc;
  assign agent_clk_o = agent_i & osc;
  // Loopback trace, or board distribution when the host does not drive
  assign #2 sync_in_o = ext_i ? osc : sync_out_i;
endmodule

// ---- bench/scd_assertions.sv ----
// Port-level checks for the clock derivation top
`timescale 1ns/1ps
module scd_assertions
  import scd_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        sync_out_o,
  input wire logic [4:0]  bus_clk_out_o,
  input wire logic        mem1_clock_p_o,
  input wire logic        mem1_clock_n_o,
  input wire logic        local_sync_output_o,
  input wire logic [2:0]  local_bus_clock_outputs_o,
  input wire logic        sec_clk_o,
  input wire logic        dma_clk_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_resp_held:
    assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
      else $error("write response dropped");
  chk_read_held:
    assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data moved");
  chk_read_answer:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
  chk_gate_sync:
    assert property (|bus_clk_out_o |-> sync_out_o) else $error("stray bus clock");
  chk_pair_apart:
    assert property (!(mem1_clock_p_o && mem1_clock_n_o)) else $error("pair both high");
  chk_lb_copies:
    assert property (local_bus_clock_outputs_o == {3{local_sync_output_o}})
      else $error("local outputs differ");
  chk_dma_pulse:
    assert property (dma_clk_o |=> !dma_clk_o) else $error("dma pulse wrong");
  chk_sec_pulse:
    assert property ($rose(sec_clk_o) |-> ##[1:3] !sec_clk_o) else $error("sec pulse long");
endmodule

bind scd_top scd_assertions u_chk (.*);

// ---- bench/system_clock_derivation_test.sv ----
// Self-checking bench for the system clock derivation block
`timescale 1ns/1ps
module system_clock_derivation_test
  import scd_pkg::*;
;
  logic        clk_i, nrst_i, halve_strap_i, host_mode_select_i, bus_clock_drive_i;
  logic        s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
  logic        s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic        s_axi_arready_o, s_axi_rvalid_o, sync_out_o, mem1_clock_p_o, mem1_clock_n_o;
  logic        local_sync_output_o, sec_clk_o, dma_clk_o, clkin_i, agent_clk_i, sync_in_i;
  logic        agent, ext;
  logic [1:0]  reset_source_i, s_axi_bresp_o, s_axi_rresp_o, resp;
  logic [2:0]  local_bus_clock_outputs_o;
  logic [3:0]  s_axi_wstrb_i;
  logic [4:0]  bus_clk_out_o;
  logic [6:0]  cpu_pll_select_o;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, csb_mult_o;
  logic [10:0] mon;
  logic [31:0] reset_word_low_i, s_axi_wdata_i, s_axi_rdata_o, rd;
  int          n_mismatch, comparisons, slow, e[11];

  scd_top dut (.*);
  scd_board board (.sync_out_i(sync_out_o), .agent_i(agent), .ext_i(ext), .clkin_o(clkin_i),
    .agent_clk_o(agent_clk_i), .sync_in_o(sync_in_i));
  assign mon = {clkin_i, sync_out_o, bus_clk_out_o, sec_clk_o, dma_clk_o,
    local_sync_output_o, mem1_clock_p_o};

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic near(input int a, input int b);
    return a - b < 3 && b - a < 3;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o && s_axi_bready_i) break;
      if (n >= slow) s_axi_bready_i <= 1'b1;
    end
    resp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
    if (n == 40) check(1'b0, 1'b1);
    if (n == 40) complete_run();
    @(posedge clk_i);
  endtask

  task automatic rdr(input logic [7:0] a);
    int n;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o && s_axi_rready_i) break;
      if (n >= slow) s_axi_rready_i <= 1'b1;
    end
    {resp, rd} = {s_axi_rresp_o, s_axi_rdata_o};
    s_axi_rready_i <= 1'b0;
    if (n == 40) check(1'b0, 1'b1);
    if (n == 40) complete_run();
    @(posedge clk_i);
  endtask

  task automatic boot(input logic h, input logic dv, input logic hv, input logic [1:0] src);
    {nrst_i, host_mode_select_i, bus_clock_drive_i} <= {1'b0, h, dv};
    {halve_strap_i, reset_source_i, agent, ext} <= {hv, src, !h, h && !dv};
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  // Toggle counts of every watched clock over a window
  task automatic count(input int cyc);
    logic [10:0] p;
    p = mon;
    e = '{default: 0};
    repeat (cyc)
    begin
      @(posedge clk_i);
      for (int k = 0; k < 11; k++) e[k] += int'(mon[k] ^ p[k]);
      p = mon;
    end
  endtask

  task automatic t_modes();
    logic [2:0] m;
    for (int i = 0; i < 3; i++)
    begin
      m = i[1] ? 3'h7 : {2'h0, i[0]};
      boot(m[0], m[1], m[2], 2'h0);
      count(160);
      check(near(e[9], m[2] ? 5 : 10), 1);
      rdr(OFS_STATUS);
      check(rd, {26'h0, !m[0] ? PRIM_AGENT : !m[1] ? PRIM_SYNC_IN : PRIM_CLKIN, 1'b1, m});
      check(csb_mult_o, 8'(reset_word_low_i[3:0] * (m[2] + 1)));
      check(cpu_pll_select_o, reset_word_low_i[10:4]);
      rdr(OFS_RATIOS);
      check(rd[17:8], {2'(reset_word_low_i[16] + 1), 3'h0, reset_word_low_i[15:11]});
      rdr(OFS_RESET_LOW);
      check(rd, reset_word_low_i);
    end
    for (int j = 1; j < 4; j++)
    begin
      boot(1'b1, 1'b1, 1'b0, 2'(j));
      rdr(OFS_RESET_LOW);
      check(rd, j == 1 ? RCW_OPT1 : j == 2 ? RCW_OPT2 : RCW_OPT3);
    end
  endtask

  task automatic t_regs();
    boot(1'b1, 1'b1, 1'b1, 2'h0);
    slow = 3;
    rdr(OFS_UNIT_CLK);
    check(rd, {27'h0, 1'b1, 2'h0, SEC_THIRD});
    wr(8'h18, 32'h0000_0001);
    check(resp, AXI_SLVERR);
    slow = 0;
    rdr(8'h20);
    check({resp, rd}, {AXI_SLVERR, 32'h0000_0000});
    wr(OFS_RESET_LOW, 32'h0000_0000);
    rdr(OFS_RESET_LOW);
    check(rd, reset_word_low_i);
  endtask

  task automatic t_clocks();
    wr(OFS_OUT_CLK_CTRL, 32'h0000_0005);
    count(400);
    check(e[5] + e[7] + e[8], 0);
    check(e[4] > 4 && near(e[4], e[9]) && near(e[6], e[9]), 1);
    check(near(e[10], 2 * e[9]), 1);
    for (int c = 0; c < 4; c++)
    begin
      wr(OFS_UNIT_CLK, {27'h0, c[0], 2'h0, c[1:0]});
      repeat (12) @(posedge clk_i);
      count(60);
      check(near(e[3], c == 0 ? 0 : 60 / c) && near(e[2], c[0] ? 60 : 0), 1);
    end
    for (int d = 0; d < 4; d++)
    begin
      wr(OFS_LB_RATIO, 32'(d));
      repeat (12) @(posedge clk_i);
      count(64);
      check(near(e[1], 64 >> (d == 3 ? 2 : d)) && near(e[0], 64), 1);
    end
  endtask

  initial
  begin
    {nrst_i, halve_strap_i, host_mode_select_i, bus_clock_drive_i, agent, ext} = '0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    {reset_source_i, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, slow} = '0;
    reset_word_low_i = 32'h0301_4834;
    s_axi_wstrb_i = 4'hF;
    t_modes();
    t_regs();
    t_clocks();
    complete_run();
  end
endmodule
